// ===== hdl/pcr_regs.vh
// Command offsets, field positions, reset values and timing counts of the protection command registers.
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// Command codes; the odd-parity variant has bit 7 set and decodes the same.
`define PCR_OFF_SENSE_SHORT 7'h22
`define PCR_OFF_WDOG_TIME 7'h26
`define PCR_OFF_INT_MASK 7'h2c
`define PCR_OFF_BUS_SHORT 7'h36
`define PCR_OFF_DISCONTINUOUS_ONLY_ENABLE 7'h3a
`define PCR_OFF_ZVS_CFG 7'h3e

// Reset values.
`define PCR_RST_SENSE_SHORT 8'h32
`define PCR_RST_WDOG_TIME 8'h01
`define PCR_RST_INT_MASK 16'h0000
`define PCR_RST_BUS_SHORT 8'h02
`define PCR_RST_DISCONTINUOUS_ONLY_ENABLE 8'h00
`define PCR_RST_ZVS_CFG 16'h0000

// Field positions.
`define PCR_RESP_HI 1
`define PCR_RESP_LO 0
`define PCR_WDOG_HI 1
`define PCR_WDOG_LO 0
`define PCR_DCM_BIT 2
`define PCR_FWD_VALLEY_BIT 11
`define PCR_ZVS_EN_BIT 10
`define PCR_ZVS_DLY_HI 7
`define PCR_ZVS_DLY_LO 5
`define PCR_ZVS_ON_HI 4
`define PCR_ZVS_ON_LO 0
`define PCR_SRC_SENSE_SHORT 3

// Response and watchdog encodings.
`define PCR_RESP_DISABLE 2'h3
`define PCR_WDOG_OFF 2'h0

// Watchdog base period: 0.5 s in milliseconds and at 125 MHz.
`define PCR_WDOG_BASE_MS 500
`define PCR_CLK_MHZ 125
`define PCR_WDOG_BASE_CYC (`PCR_WDOG_BASE_MS * 1000 * `PCR_CLK_MHZ)

// Seven-bit slave address on the serial bus.
`define PCR_DEV_ADDR 7'h18

`endif

// ===== hdl/pcr_command_regs.v
// Serial-bus command register bank with fault response, interrupt and watchdog logic.
// How it works
// - Sense pin short response: 11 disable output, 10 auto-restart, 01 latch-off, 00 none.
// - Mask bits 7, 6, 5 enable bus switch short, secondary control, bypass latch-off.
// - Mask bit 8 enables the operating mode flag interrupt source.
// - Mask bits 4..0 enable peak timer, sense short, short-circuit, undervoltage, overvoltage.
// - Sense short disable-output response drops the output switch enable and issues a reset.
// - After that reset, auto-restart follows when operating conditions allow it.
// - Zero-volt config bit 11 enables forward-conduction valley switching.
// - Zero-volt config bit 10 enables the synchronous-rectifier zero-volt mode.
// - Delay count bits 7:5, on count bits 4:0, each programmed at least 3.
`timescale 1ns/1ps
`include "pcr_regs.vh"

module pcr_command_regs #(
	parameter WDOG_BASE_CYC = `PCR_WDOG_BASE_CYC
) (
	input wire clk_sys,
	input wire nrst,
	input wire scl,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe,
	input wire [8:0] faultSources,
	input wire restartOk,
	output reg outputSwitchEnable,
	output reg faultReset,
	output reg intPulse,
	output reg watchdogExpired,
	output reg [1:0] senseShortResponse,
	output reg [1:0] busShortResponse,
	output reg discontinuousOnly,
	output reg forwardValleyEnable,
	output reg syncRectZeroVoltMode,
	output reg [2:0] zeroVoltDelayCount,
	output reg [4:0] zeroVoltOnCount
);

	localparam ST_IDLE = 4'h0;
	localparam ST_ADDR = 4'h1;
	localparam ST_ACK_ADDR = 4'h2;
	localparam ST_CMD = 4'h3;
	localparam ST_ACK_CMD = 4'h4;
	localparam ST_DATA = 4'h5;
	localparam ST_ACK_DATA = 4'h6;
	localparam ST_READ = 4'h7;
	localparam ST_READ_ACK = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage feeds only the second.
	reg [1:0] sclSync_r;
	reg [1:0] sdaSync_r;
	reg sclDly_r;
	reg sdaDly_r;
	wire sclRise = sclSync_r[1] & ~sclDly_r;
	wire sclFall = ~sclSync_r[1] & sclDly_r;
	wire startCond = sclSync_r[1] & sclDly_r & ~sdaSync_r[1] & sdaDly_r;
	wire stopCond = sclSync_r[1] & sclDly_r & sdaSync_r[1] & ~sdaDly_r;

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			sclDly_r <= 1'b1;
			sdaDly_r <= 1'b1;
		end
		else
		begin
			sclSync_r <= {sclSync_r[0], scl};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			sclDly_r <= sclSync_r[1];
			sdaDly_r <= sdaSync_r[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register storage.
	reg [7:0] senseCfg_r;
	reg [7:0] wdogCfg_r;
	reg [15:0] intMask_r;
	reg [7:0] busCfg_r;
	reg [7:0] dcmCfg_r;
	reg [15:0] zvsCfg_r;

	// Serial engine state.
	reg [3:0] st_r;
	reg [3:0] bitCnt_r;
	reg [7:0] shift_r;
	reg [7:0] tx_r;
	reg [6:0] cmd_r;
	reg [7:0] low_r;
	reg [7:0] high_r;
	reg [1:0] nBytes_r;
	reg readHigh_r;
	reg masterNack_r;
	reg commit_r;

	// Only the interrupt mask reads back; the rest are write-only and read zero.
	wire [15:0] readWord = (cmd_r == `PCR_OFF_INT_MASK) ? intMask_r : 16'h0000;
	wire endOfTransfer = startCond | stopCond;

	////////////////////////////////////////////////////////////////////////
	// Byte engine: address, command, then one or two data bytes, low byte first.
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= ST_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			cmd_r <= 7'h00;
			low_r <= 8'h00;
			high_r <= 8'h00;
			nBytes_r <= 2'h0;
			readHigh_r <= 1'b0;
			masterNack_r <= 1'b0;
			sdaOe <= 1'b0;
			sdaOut <= 1'b0;
			commit_r <= 1'b0;
		end
		else
		begin
			// A stop or repeated start closes the transfer and commits any data seen.
			commit_r <= endOfTransfer & (nBytes_r != 2'h0);
			// The byte count lives until the commit cycle, which needs it to choose one or two bytes.
			if (commit_r)
				nBytes_r <= 2'h0;
			if (endOfTransfer)
			begin
				st_r <= startCond ? ST_ADDR : ST_IDLE;
				bitCnt_r <= 4'h0;
				sdaOe <= 1'b0;
			end
			else if (sclRise)
			begin
				if (st_r == ST_ADDR || st_r == ST_CMD || st_r == ST_DATA)
				begin
					shift_r <= {shift_r[6:0], sdaSync_r[1]};
					bitCnt_r <= bitCnt_r + 4'h1;
				end
				else if (st_r == ST_READ_ACK)
					masterNack_r <= sdaSync_r[1];
			end
			else if (sclFall)
			begin
				case (st_r)
					ST_ADDR, ST_CMD, ST_DATA:
					begin
						if (bitCnt_r == 4'h8)
						begin
							bitCnt_r <= 4'h0;
							if (st_r == ST_ADDR)
							begin
								sdaOe <= (shift_r[7:1] == `PCR_DEV_ADDR);
								st_r <= (shift_r[7:1] == `PCR_DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
								readHigh_r <= shift_r[0];
							end
							else if (st_r == ST_CMD)
							begin
								// Bit 7 is the odd-parity variant of the same command.
								cmd_r <= shift_r[6:0];
								sdaOe <= 1'b1;
								st_r <= ST_ACK_CMD;
							end
							else
							begin
								if (nBytes_r == 2'h0)
									low_r <= shift_r;
								else
									high_r <= shift_r;
								if (nBytes_r != 2'h2)
									nBytes_r <= nBytes_r + 2'h1;
								sdaOe <= 1'b1;
								st_r <= ST_ACK_DATA;
							end
						end
					end
					ST_ACK_ADDR:
					begin
						if (readHigh_r)
						begin
							sdaOe <= ~readWord[7];
							tx_r <= {readWord[6:0], 1'b0};
							bitCnt_r <= 4'h1;
							readHigh_r <= 1'b0;
							st_r <= ST_READ;
						end
						else
						begin
							sdaOe <= 1'b0;
							st_r <= ST_CMD;
						end
					end
					ST_ACK_CMD, ST_ACK_DATA:
					begin
						sdaOe <= 1'b0;
						st_r <= ST_DATA;
					end
					ST_READ:
					begin
						if (bitCnt_r == 4'h8)
						begin
							sdaOe <= 1'b0;
							st_r <= ST_READ_ACK;
						end
						else
						begin
							sdaOe <= ~tx_r[7];
							tx_r <= {tx_r[6:0], 1'b0};
							bitCnt_r <= bitCnt_r + 4'h1;
						end
					end
					ST_READ_ACK:
					begin
						// A further byte after the high byte repeats the high byte.
						if (masterNack_r)
							st_r <= ST_IDLE;
						else
						begin
							sdaOe <= ~readWord[15];
							tx_r <= {readWord[14:8], 1'b0};
							bitCnt_r <= 4'h1;
							st_r <= ST_READ;
						end
					end
					default:
						st_r <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes; a one-byte write to a word register leaves the high byte alone.
	wire [15:0] wrWord = {(nBytes_r == 2'h2) ? high_r : 8'h00, low_r};
	wire maskWrite = commit_r & (cmd_r == `PCR_OFF_INT_MASK);
	wire [15:0] maskNext = (nBytes_r == 2'h2) ? wrWord : {intMask_r[15:8], low_r};

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			senseCfg_r <= `PCR_RST_SENSE_SHORT;
			wdogCfg_r <= `PCR_RST_WDOG_TIME;
			intMask_r <= `PCR_RST_INT_MASK;
			busCfg_r <= `PCR_RST_BUS_SHORT;
			dcmCfg_r <= `PCR_RST_DISCONTINUOUS_ONLY_ENABLE;
			zvsCfg_r <= `PCR_RST_ZVS_CFG;
		end
		else if (commit_r)
		begin
			if (cmd_r == `PCR_OFF_SENSE_SHORT)
				senseCfg_r <= low_r;
			else if (cmd_r == `PCR_OFF_WDOG_TIME)
				wdogCfg_r <= low_r;
			else if (cmd_r == `PCR_OFF_INT_MASK)
				intMask_r <= maskNext;
			else if (cmd_r == `PCR_OFF_BUS_SHORT)
				busCfg_r <= low_r;
			else if (cmd_r == `PCR_OFF_DISCONTINUOUS_ONLY_ENABLE)
				dcmCfg_r <= low_r;
			else if (cmd_r == `PCR_OFF_ZVS_CFG)
				zvsCfg_r <= (nBytes_r == 2'h2) ? wrWord : {zvsCfg_r[15:8], low_r};
		end
	end

	// Configuration outputs follow the registers one cycle later.
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			senseShortResponse <= 2'h0;
			busShortResponse <= 2'h0;
			discontinuousOnly <= 1'b0;
			forwardValleyEnable <= 1'b0;
			syncRectZeroVoltMode <= 1'b0;
			zeroVoltDelayCount <= 3'h0;
			zeroVoltOnCount <= 5'h0;
		end
		else
		begin
			senseShortResponse <= senseCfg_r[`PCR_RESP_HI:`PCR_RESP_LO];
			busShortResponse <= busCfg_r[`PCR_RESP_HI:`PCR_RESP_LO];
			discontinuousOnly <= dcmCfg_r[`PCR_DCM_BIT];
			forwardValleyEnable <= zvsCfg_r[`PCR_FWD_VALLEY_BIT];
			syncRectZeroVoltMode <= zvsCfg_r[`PCR_ZVS_EN_BIT];
			// Values below 3 pass unchanged; the timing step is only seen from 3 up.
			zeroVoltDelayCount <= zvsCfg_r[`PCR_ZVS_DLY_HI:`PCR_ZVS_DLY_LO];
			zeroVoltOnCount <= zvsCfg_r[`PCR_ZVS_ON_HI:`PCR_ZVS_ON_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt: rising edge of any enabled source gives one pulse, then disarms.
	reg [8:0] srcDly_r;
	reg intArmed_r;
	wire [8:0] srcRise = faultSources & ~srcDly_r;
	wire intHit = intArmed_r & (|(srcRise & intMask_r[8:0]));

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			srcDly_r <= 9'h000;
			intArmed_r <= 1'b0;
			intPulse <= 1'b0;
		end
		else
		begin
			srcDly_r <= faultSources;
			intPulse <= intHit;
			// A mask write in the same cycle as a pulse wins and re-arms unless the new mask is zero.
			if (maskWrite)
				intArmed_r <= (maskNext != 16'h0000);
			else if (intHit)
				intArmed_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Disable-output response and the restart that may follow it.
	reg disabledByFault_r;
	wire senseShortHit = srcRise[`PCR_SRC_SENSE_SHORT] & (senseCfg_r[1:0] == `PCR_RESP_DISABLE);

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			outputSwitchEnable <= 1'b1;
			faultReset <= 1'b0;
			disabledByFault_r <= 1'b0;
		end
		else
		begin
			faultReset <= senseShortHit;
			if (senseShortHit)
			begin
				outputSwitchEnable <= 1'b0;
				disabledByFault_r <= 1'b1;
			end
			else if (disabledByFault_r & restartOk & ~faultSources[`PCR_SRC_SENSE_SHORT])
			begin
				outputSwitchEnable <= 1'b1;
				disabledByFault_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Communication watchdog; every committed write restarts the count.
	reg [28:0] wdogCnt_r;
	wire [1:0] wdogSel = wdogCfg_r[`PCR_WDOG_HI:`PCR_WDOG_LO];
	wire [31:0] wdogBaseFull = WDOG_BASE_CYC;
	wire [28:0] wdogBase = wdogBaseFull[28:0]; // Four base periods still fit in 29 bits.
	wire [28:0] wdogLimit = (wdogSel == 2'h3) ? {wdogBase[26:0], 2'h0} :
		(wdogSel == 2'h2) ? {wdogBase[27:0], 1'b0} : wdogBase;

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			wdogCnt_r <= 29'h0;
			watchdogExpired <= 1'b0;
		end
		else
		begin
			watchdogExpired <= 1'b0;
			if (commit_r || wdogSel == `PCR_WDOG_OFF)
				wdogCnt_r <= 29'h0;
			else if (wdogCnt_r >= wdogLimit - 29'h1)
			begin
				wdogCnt_r <= 29'h0;
				watchdogExpired <= 1'b1;
			end
			else
				wdogCnt_r <= wdogCnt_r + 29'h1;
		end
	end

endmodule // pcr_command_regs

// ===== tb/pcr_command_regs_checker.sv
// Concurrent checks on the fault response, interrupt and watchdog outputs.
`timescale 1ns/1ps
module pcr_command_regs_checker (
	input wire clk_sys,
	input wire nrst,
	input wire [8:0] faultSources,
	input wire restartOk,
	input wire outputSwitchEnable,
	input wire faultReset,
	input wire intPulse,
	input wire watchdogExpired,
	input wire [1:0] senseShortResponse
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// A sense short arriving while the output is on and set to be disabled.
	sequence sHit;
		$rose(faultSources[3]) ##0 (senseShortResponse == 2'h3 && outputSwitchEnable);
	endsequence
	sequence sOff;
		faultReset && !outputSwitchEnable;
	endsequence
	a_fault_drops_output: assert property (sHit |-> ##[1:2] sOff)
		else $error("Sense short did not drop the output switch");
	a_reset_with_off: assert property (faultReset |-> !outputSwitchEnable ##1 !faultReset)
		else $error("Fault reset pulse malformed");
	a_off_needs_disable: assert property ($fell(outputSwitchEnable) |-> faultReset && senseShortResponse == 2'h3)
		else $error("Output dropped without the disable response");
	a_restart_needs_ok: assert property ($rose(outputSwitchEnable) |-> $past(restartOk) && !$past(faultSources[3]))
		else $error("Output restarted without permission");
	a_off_holds: assert property (!outputSwitchEnable && !restartOk |=> !outputSwitchEnable)
		else $error("Output restarted while restart not allowed");
	a_int_has_cause: assert property (intPulse |-> ($past(faultSources) != 9'h0 || $past(faultSources, 2) != 9'h0))
		else $error("Interrupt without any active source");
	a_int_disarms: assert property (intPulse |=> !intPulse [*8])
		else $error("Interrupt repeated without a new mask write");
	a_wdog_spaced: assert property (watchdogExpired |=> !watchdogExpired [*8])
		else $error("Watchdog expiry pulses too close");
endmodule // pcr_command_regs_checker

bind pcr_command_regs pcr_command_regs_checker pcr_command_regs_checker_inst (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.faultSources(faultSources),
	.restartOk(restartOk),
	.outputSwitchEnable(outputSwitchEnable),
	.faultReset(faultReset),
	.intPulse(intPulse),
	.watchdogExpired(watchdogExpired),
	.senseShortResponse(senseShortResponse)
);

// ===== tb/pcr_bus_master.sv
// Serial bus master model writing command registers over an open-drain data line.
`timescale 1ns/1ps
`include "pcr_regs.vh"
module pcr_bus_master (
	output logic scl,
	output logic sdaLow,
	input wire logic sda,
	output logic [3:0] nNak
);
	// Idle bus: clock parked high, data released to the pull-up.
	initial
	begin
		scl = 1;
		sdaLow = 0;
		nNak = 0;
	end
	// One bit per 80 ns; data moves mid-way through the low phase, away from both clock edges.
	task bitOut(input logic b);
	begin
		#20 sdaLow = !b;
		#20 scl = 1;
		#40 scl = 0;
	end
	endtask
	// Eight bits, then release and sample the acknowledge with the clock high.
	task sendByte(input logic [7:0] d);
	begin
		for (int k = 7; k >= 0; k--)
			bitOut(d[k]);
		#20 sdaLow = 0;
		#20 scl = 1;
		#20 if (sda !== 1'b0) nNak = nNak + 1;
		#20 scl = 0;
	end
	endtask
	// Whole write frame, low byte first; one byte only fills the low byte.
	task write(input logic [7:0] cmd, input logic [15:0] d, input int n);
	begin
		#20 sdaLow = 1;
		#40 scl = 0;
		sendByte({`PCR_DEV_ADDR, 1'b0});
		sendByte(cmd);
		sendByte(d[7:0]);
		if (n > 1) sendByte(d[15:8]);
		#20 sdaLow = 1;
		#20 scl = 1;
		#40 sdaLow = 0;
		#40;
	end
	endtask
	// Eight bits from the slave sampled with the clock high, then acknowledge, or not after the last byte.
	task recvByte(output logic [7:0] d, input logic last);
	begin
		for (int k = 7; k >= 0; k--)
		begin
			#20 sdaLow = 0;
			#20 scl = 1;
			#20 d[k] = sda;
			#20 scl = 0;
		end
		#20 sdaLow = !last;
		#20 scl = 1;
		#40 scl = 0;
	end
	endtask
	// Command byte, repeated start, then a two-byte read, low byte first.
	task read(input logic [7:0] cmd, output logic [15:0] d);
	begin
		#20 sdaLow = 1;
		#40 scl = 0;
		sendByte({`PCR_DEV_ADDR, 1'b0});
		sendByte(cmd);
		#20 sdaLow = 0;
		#20 scl = 1;
		#20 sdaLow = 1;
		#20 scl = 0;
		sendByte({`PCR_DEV_ADDR, 1'b1});
		recvByte(d[7:0], 1'b0);
		recvByte(d[15:8], 1'b1);
		#20 sdaLow = 1;
		#20 scl = 1;
		#40 sdaLow = 0;
		#40;
	end
	endtask
endmodule // pcr_bus_master

// ===== tb/tb_pcr_command_regs.sv
// Self-checking bench for the protection command register bank.
`timescale 1ns/1ps
`include "pcr_regs.vh"
module tb_pcr_command_regs;
	localparam int BASE = 1000;
	logic clk_sys = 0;
	logic nrst = 0;
	logic [8:0] faultSources = 9'h000;
	logic restartOk = 0;
	wire scl, sdaLow, sdaOut, sdaOe, faultReset, intPulse, watchdogExpired, outputSwitchEnable;
	wire discontinuousOnly, forwardValleyEnable, syncRectZeroVoltMode;
	wire [1:0] senseShortResponse, busShortResponse;
	wire [2:0] zeroVoltDelayCount;
	wire [4:0] zeroVoltOnCount;
	wire [3:0] nNak;
	wire sda = !(sdaLow || (sdaOe && !sdaOut));
	logic [3:0] nInt = 0, nRst = 0, nWd = 0, eInt = 0, eRst = 0, eWd = 0;
	logic [1:0] eSense = 2'h2, eBus = 2'h2;
	logic eOse = 1, eDcm = 0, eFwd = 0, eZvs = 0;
	logic [2:0] eDly = 0;
	logic [4:0] eOn = 0;
	logic [31:0] r;
	logic [47:0] qV[$];
	logic [15:0] rdWord = 0, eRd = 0;
	int n_mismatch = 0, n_checks = 0, cyc = 0, seed = 58546, i;
	event chkEv;
	wire [47:0] obs = {rdWord, nNak, nWd, nInt, nRst, outputSwitchEnable, senseShortResponse, busShortResponse,
		discontinuousOnly, forwardValleyEnable, syncRectZeroVoltMode, zeroVoltDelayCount, zeroVoltOnCount};
	pcr_command_regs #(.WDOG_BASE_CYC(BASE)) pcr_command_regs_inst (.clk_sys(clk_sys), .nrst(nrst),
		.scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .faultSources(faultSources),
		.restartOk(restartOk), .outputSwitchEnable(outputSwitchEnable), .faultReset(faultReset),
		.intPulse(intPulse), .watchdogExpired(watchdogExpired), .senseShortResponse(senseShortResponse),
		.busShortResponse(busShortResponse), .discontinuousOnly(discontinuousOnly),
		.forwardValleyEnable(forwardValleyEnable), .syncRectZeroVoltMode(syncRectZeroVoltMode),
		.zeroVoltDelayCount(zeroVoltDelayCount), .zeroVoltOnCount(zeroVoltOnCount));
	pcr_bus_master pcr_bus_master_inst (.scl(scl), .sdaLow(sdaLow), .sda(sda), .nNak(nNak));
	////////////////////////////////////////////////////////////
	// Clock at 125 MHz.
	always #4 clk_sys = !clk_sys;
	// Pulse counters and a hang limit well above the expected run length.
	always @(posedge clk_sys)
	begin
		if (intPulse === 1'b1) nInt <= nInt + 1;
		if (faultReset === 1'b1) nRst <= nRst + 1;
		if (watchdogExpired === 1'b1) nWd <= nWd + 1;
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	// The watcher takes the oldest note whenever a snapshot is announced.
	always @(chkEv) check(obs, qV.pop_front());
	task check(input logic [47:0] seen, input logic [47:0] want);
	begin
		n_checks++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	end
	endtask
	task test_done();
	begin
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	// Note the whole expected state; the acknowledge-miss count is always zero.
	task snap();
	begin
		@(posedge clk_sys);
		#1 qV.push_back({eRd, 4'h0, eWd, eInt, eRst, eOse, eSense, eBus, eDcm, eFwd, eZvs, eDly, eOn});
		->chkEv;
	end
	endtask
	// Frames start just after a clock edge so no pin moves on one; commit lands a few cycles after the stop.
	task wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
	begin
		@(posedge clk_sys);
		#1 pcr_bus_master_inst.write(cmd, d, n);
		repeat (12) @(posedge clk_sys);
	end
	endtask
	task hit(input int k);
	begin
		@(posedge clk_sys);
		#1 faultSources[k] = 1;
		repeat (4) @(posedge clk_sys);
		#1 faultSources[k] = 0;
		repeat (4) @(posedge clk_sys);
	end
	endtask
	////////////////////////////////////////////////////////////
	// Main sequence; the watchdog is off from the second write until its own test.
	initial
	begin
		repeat (4) @(posedge clk_sys);
		#1 nrst = 1;
		repeat (4) @(posedge clk_sys);
		snap();
		// The default half-second watchdog must fire once before the first write.
		repeat (BASE) @(posedge clk_sys);
		eWd = 1;
		snap();
		wr(8'h86, 16'h0000, 1);
		wr(`PCR_OFF_WDOG_TIME, 16'h0000, 1);
		$display("Test defaults done");
		for (i = 0; i < 9; i++)
		begin
			wr(`PCR_OFF_INT_MASK, 16'h0001 << i, 2);
			hit((i + 1) % 9);
			hit(i);
			eInt++;
			hit(i);
			snap();
		end
		$display("Test interrupts done");
		for (i = 0; i < 4; i++)
		begin
			r = $random(seed);
			wr({i[0], `PCR_OFF_SENSE_SHORT}, {8'h00, r[7:2], i[1:0]}, 1);
			eSense = i[1:0];
			hit(3);
			if (i == 3) eOse = 0;
			if (i == 3) eRst++;
			snap();
		end
		@(posedge clk_sys);
		#1 restartOk = 1;
		eOse = 1;
		snap();
		$display("Test sense short done");
		for (i = 0; i < 3; i++)
		begin
			r = $random(seed);
			r[7:5] = 3 + r[7:5] % 5;
			r[4:0] = 3 + r[4:0] % 29;
			wr(`PCR_OFF_ZVS_CFG, r[15:0], 2);
			wr(`PCR_OFF_BUS_SHORT, r[23:16], 1);
			wr(`PCR_OFF_DISCONTINUOUS_ONLY_ENABLE, r[31:24], 1);
			{eFwd, eZvs, eDly, eOn} = {r[11:10], r[7:0]};
			eBus = r[17:16];
			eDcm = r[26];
			snap();
		end
		wr(8'h40, r[15:0], 2);
		snap();
		$display("Test config done");
		// Full mask write, then a one-byte write that must keep the high byte, then read it back.
		r = $random(seed);
		wr(`PCR_OFF_INT_MASK, r[15:0], 2);
		wr(`PCR_OFF_INT_MASK, {8'h00, r[31:24]}, 1);
		@(posedge clk_sys);
		#1 pcr_bus_master_inst.read(`PCR_OFF_INT_MASK, rdWord);
		eRd = {r[15:8], r[31:24]};
		snap();
		$display("Test read-back done");
		// Field 11 selects two seconds, four base periods after the commit.
		wr(`PCR_OFF_WDOG_TIME, 16'h0003, 1);
		repeat (4 * BASE - 300) @(posedge clk_sys);
		snap();
		repeat (500) @(posedge clk_sys);
		eWd = 2;
		snap();
		$display("Test watchdog done");
		repeat (2) @(posedge clk_sys);
		test_done();
	end
endmodule // tb_pcr_command_regs
